// [hwc_cfg.sv]
// host write controller configuration register and data path steering
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module hwc_cfg
    import hwc_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // register port
    input wire logic [hwc_pkg::ADDR_W-1:0] i_addr,
    input wire logic [hwc_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [hwc_pkg::DATA_W-1:0] o_rdata,
    // host data stream
    input wire logic i_host_valid,
    output logic o_host_ready,
    input wire logic [hwc_pkg::DATA_W-1:0] i_host_data_lines,
    // controller path
    output logic o_rwc_valid,
    input wire logic i_rwc_ready,
    output logic [hwc_pkg::DATA_W-1:0] o_rwc_data,
    output logic o_rwc_mirror,
    output logic [1:0] o_rwc_rot,
    output logic [2:0] o_rwc_type,
    output logic o_rwc_srst,
    // direct memory path
    output logic o_dir_valid,
    input wire logic i_dir_ready,
    output logic [hwc_pkg::DATA_W-1:0] o_dir_data,
    // status
    output logic o_rwc_en,
    output logic o_type_rsvd
);
    import hwc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [DATA_W-1:0] cfg_q;
    logic [DATA_W-1:0] rdata_q;
    logic srst_q;
    logic rsvd_hit_q;
    logic en_q;
    logic type_rsvd_q;
    logic cfg_wr;
    logic srst_req;
    logic en;
    logic [DATA_W-1:0] fin_data;
    logic fin_ready;
    logic fout_valid;
    logic fout_ready;
    logic [DATA_W-1:0] fout_data;
    logic rwc_valid_d;
    logic dir_valid_d;
    logic take;

    function automatic logic [DATA_W-1:0] swap_bytes(input logic [DATA_W-1:0] v);
        swap_bytes = {v[7:0], v[15:8]};
    endfunction

    assign cfg_wr = i_wr && (i_addr == REG_CFG);
    assign srst_req = cfg_wr && i_wdata[BIT_SRST];
    assign en = cfg_q[BIT_EN];

    ////////////////////////////////////////////////////////////////////////
    // config register
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            cfg_q <= CFG_RESET;
        else if (srst_req)
            cfg_q <= (i_wdata & CFG_RW_MASK) & ~(DATA_W'(1) << BIT_EN);
        else if (cfg_wr)
            cfg_q <= i_wdata & CFG_RW_MASK;
    end

    // soft reset pulse, one cycle after the write
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            srst_q <= 1'b0;
        else
            srst_q <= srst_req;
    end

    // sticky flag: host wrote to a reserved location; cleared by soft reset
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            rsvd_hit_q <= 1'b0;
        else if (i_wr && (i_addr == REG_RSVD_A || i_addr == REG_RSVD_B
                 || i_addr == REG_RSVD_C || i_addr == REG_RSVD_D))
            rsvd_hit_q <= 1'b1;
        else if (srst_q)
            rsvd_hit_q <= 1'b0;
    end

    // read data; reserved bits and the reset bit read 0
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            rdata_q <= '0;
        else if (i_rd)
        begin
            case (i_addr)
                REG_CFG: rdata_q <= cfg_q & CFG_RW_MASK;
                REG_STAT: rdata_q <= {14'h0000, rsvd_hit_q, fout_valid};
                default: rdata_q <= '0;
            endcase
        end
    end
    assign o_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // swap only acts on the controller path
    assign fin_data = (en && cfg_q[BIT_SWAP]) ? swap_bytes(i_host_data_lines)
                                              : i_host_data_lines;
    assign o_host_ready = fin_ready;

    hwc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_flush(srst_q),
        .i_in_valid(i_host_valid),
        .o_in_ready(fin_ready),
        .i_in_data(fin_data),
        .o_out_valid(fout_valid),
        .i_out_ready(fout_ready),
        .o_out_data(fout_data)
    );

    // output stage register; stalls fifo when destination is busy
    assign take = !(o_rwc_valid && !i_rwc_ready) && !(o_dir_valid && !i_dir_ready);
    assign fout_ready = take && !srst_q;
    assign rwc_valid_d = fout_valid && fout_ready && en;
    assign dir_valid_d = fout_valid && fout_ready && !en;

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_rwc_valid <= 1'b0;
            o_dir_valid <= 1'b0;
            o_rwc_data <= '0;
            o_dir_data <= '0;
        end
        else if (srst_q)
        begin
            o_rwc_valid <= 1'b0;
            o_dir_valid <= 1'b0;
        end
        else if (take)
        begin
            o_rwc_valid <= rwc_valid_d;
            o_dir_valid <= dir_valid_d;
            if (rwc_valid_d)
                o_rwc_data <= fout_data;
            if (dir_valid_d)
                o_dir_data <= fout_data;
        end
    end

    // mode fields seen by the controller; forced neutral while disabled
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            en_q <= 1'b0;
            o_rwc_mirror <= 1'b0;
            o_rwc_rot <= HWC_ROT_0;
            o_rwc_type <= HWC_YUV422_IL;
            type_rsvd_q <= 1'b0;
            o_rwc_srst <= 1'b0;
        end
        else
        begin
            en_q <= en;
            o_rwc_mirror <= en && cfg_q[BIT_MIRROR];
            o_rwc_rot <= en ? cfg_q[BIT_ROT_LO +: 2] : HWC_ROT_0;
            o_rwc_type <= en ? cfg_q[BIT_TYPE_LO +: 3] : HWC_YUV422_IL;
            type_rsvd_q <= en && (cfg_q[BIT_TYPE_LO +: 3] > TYPE_MAX);
            o_rwc_srst <= srst_req;
        end
    end
    assign o_rwc_en = en_q;
    assign o_type_rsvd = type_rsvd_q;

    ////////////////////////////////////////////////////////////////////////
    AST_SRST_CLEARS_EN: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        srst_req |=> !cfg_q[BIT_EN]) else $error("soft reset left enable set");
    AST_SRST_PULSE: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        srst_req |=> o_rwc_srst ##1 (o_rwc_srst == $past(srst_req)))
        else $error("soft reset pulse wrong");
    AST_SRST_READ0: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (i_rd && i_addr == REG_CFG) |=> !o_rdata[BIT_SRST]) else $error("reset bit read 1");
    AST_DIS_NEUTRAL: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        !en |=> (!o_rwc_mirror && o_rwc_rot == 2'h0 && o_rwc_type == 3'h0))
        else $error("modes active while disabled");
    AST_BYPASS: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (!en && fout_valid && fout_ready && !srst_q) |=> o_dir_valid && !o_rwc_valid)
        else $error("disabled word not sent direct");
    AST_ROUTE: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (en && fout_valid && fout_ready && !srst_q) |=> o_rwc_valid && o_rwc_data == $past(fout_data))
        else $error("enabled word not routed to controller");
    AST_SWAP: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (en && cfg_q[BIT_SWAP]) |-> fin_data == {i_host_data_lines[7:0], i_host_data_lines[15:8]})
        else $error("swap not applied");
    AST_MIRROR: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (en && cfg_q[BIT_MIRROR]) |=> o_rwc_mirror) else $error("mirror not applied");
    AST_ROT: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        en |=> o_rwc_rot == $past(cfg_q[BIT_ROT_LO +: 2])) else $error("rotation mismatch");
    AST_TYPE: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        en |=> o_rwc_type == $past(cfg_q[BIT_TYPE_LO +: 3])) else $error("type mismatch");
endmodule
`default_nettype wire

// [hwc_fifo.sv]
// small flop-based fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module hwc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_flush,
    // fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data = mem_q[rd_q];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
        nxt = (p == AW'(DEPTH-1)) ? '0 : p + AW'(1);
    endfunction

    always_ff @(posedge i_clk_sys)
    begin
        if (push)
        begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else if (i_flush)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= nxt(wr_q);
            if (pop)
                rd_q <= nxt(rd_q);
            if (push && !pop)
                cnt_q <= cnt_q + (AW+1)'(1);
            else if (pop && !push)
                cnt_q <= cnt_q - (AW+1)'(1);
        end
    end
endmodule
`default_nettype wire

// [hwc_pkg.sv]
// package: register map, field layout and type codes for the host write config block
`default_nettype none
package hwc_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 4;
    localparam logic [ADDR_W-1:0] REG_RSVD_A = 9'h06A;
    localparam logic [ADDR_W-1:0] REG_RSVD_B = 9'h070;
    localparam logic [ADDR_W-1:0] REG_RSVD_C = 9'h074;
    localparam logic [ADDR_W-1:0] REG_RSVD_D = 9'h0FE;
    localparam logic [ADDR_W-1:0] REG_CFG = 9'h180;
    localparam logic [ADDR_W-1:0] REG_STAT = 9'h182;
    localparam logic [DATA_W-1:0] CFG_RESET = 16'h0000;
    localparam int BIT_EN = 0;
    localparam int BIT_ROT_LO = 1;
    localparam int BIT_MIRROR = 3;
    localparam int BIT_SWAP = 4;
    localparam int BIT_TYPE_LO = 5;
    localparam int BIT_SRST = 15;
    localparam logic [DATA_W-1:0] CFG_RW_MASK = 16'h00FF;
    localparam logic [2:0] TYPE_MAX = 3'h4;
    typedef enum logic [1:0] {HWC_ROT_0, HWC_ROT_90, HWC_ROT_180, HWC_ROT_270} hwc_rot_e;
    typedef enum logic [2:0] {
        HWC_YUV422_IL, HWC_YUV422_SEP, HWC_YUV420_IL, HWC_YUV420_SEP, HWC_RGB565
    } hwc_type_e;
endpackage
`default_nettype wire

// [hwc_sink.sv]
// partner model: memory-side sink for the controller and direct paths
`timescale 1ns/100ps
`default_nettype none
module hwc_sink (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // stall request from the bench
    input wire logic i_stall,
    // controller path
    input wire logic i_rwc_valid,
    input wire logic [15:0] i_rwc_data,
    output logic o_rwc_ready,
    // direct memory path
    input wire logic i_dir_valid,
    input wire logic [15:0] i_dir_data,
    output logic o_dir_ready,
    // capture
    output logic [15:0] o_last,
    output logic o_last_dir,
    output logic [7:0] o_cnt
);
////////////////////////////////////////////////////////////////////////////////
    // both paths stall together, the way a busy memory would
    assign o_rwc_ready = !i_stall;
    assign o_dir_ready = !i_stall;

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_last <= 16'h0000;
            o_last_dir <= 1'b0;
            o_cnt <= 8'h00;
        end
        else if (i_rwc_valid && o_rwc_ready)
        begin
            o_last <= i_rwc_data;
            o_last_dir <= 1'b0;
            o_cnt <= o_cnt + 8'h01;
        end
        else if (i_dir_valid && o_dir_ready)
        begin
            o_last <= i_dir_data;
            o_last_dir <= 1'b1;
            o_cnt <= o_cnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

// [tb_top.sv]
// testbench: register and stream sequences for the host write config block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import hwc_pkg::*;
    logic clk, nrst, wr, rd, hv, stall, hrdy, rwc_v, rwc_r, dir_v, dir_r;
    logic mir, srst, en, rsvd, last_dir;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wd, hd, rdata, rwc_d, dir_d, last;
    logic [1:0] rot;
    logic [2:0] typ;
    logic [7:0] cnt;
    int error_cnt = 0;
    int num_checks = 0;
////////////////////////////////////////////////////////////////////////////////
    hwc_cfg uut (.i_clk_sys(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_host_valid(hv), .o_host_ready(hrdy),
        .i_host_data_lines(hd), .o_rwc_valid(rwc_v), .i_rwc_ready(rwc_r), .o_rwc_data(rwc_d),
        .o_rwc_mirror(mir), .o_rwc_rot(rot), .o_rwc_type(typ), .o_rwc_srst(srst),
        .o_dir_valid(dir_v), .i_dir_ready(dir_r), .o_dir_data(dir_d), .o_rwc_en(en),
        .o_type_rsvd(rsvd));
    hwc_sink sink (.i_clk_sys(clk), .i_nrst(nrst), .i_stall(stall), .i_rwc_valid(rwc_v),
        .i_rwc_data(rwc_d), .o_rwc_ready(rwc_r), .i_dir_valid(dir_v), .i_dir_data(dir_d),
        .o_dir_ready(dir_r), .o_last(last), .o_last_dir(last_dir), .o_cnt(cnt));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
////////////////////////////////////////////////////////////////////////////////
    task results;
        if (error_cnt == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask

    task tmo;
        $display("[FAIL] %0t wait ran out", $time);
        error_cnt++;
        results();
    endtask

    task wreg(input logic [8:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task rreg(input logic [8:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    // one word in, then wait for the sink to take it
    task xfer(input logic [15:0] d, input logic [15:0] exp, input logic dir);
        int n;
        logic [7:0] c;
        c = cnt + 8'h01;
        @(posedge clk);
        hv <= 1'b1;
        hd <= d;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (!hrdy && n < 20);
        hv <= 1'b0;
        if (!hrdy)
            tmo();
        wait_cnt(c);
        chk(last, exp);
        chk({15'h0000, last_dir}, {15'h0000, dir});
    endtask

    task wait_cnt(input logic [7:0] t);
        int n;
        n = 0;
        while (cnt !== t && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 40)
            tmo();
    endtask

    // pulse may land on the write's own edge, so look before waiting
    task watch_srst(output logic seen);
        seen = 1'b0;
        repeat (3)
        begin
            #1;
            seen = seen | srst;
            @(posedge clk);
        end
    endtask
////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        int n;
        logic [7:0] b;
        logic seen;
        nrst = 1'b0;
        {wr, rd, hv, stall} = 4'h0;
        addr = '0;
        wd = 16'h0000;
        hd = 16'h0000;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        rreg(REG_CFG, CFG_RESET);
        wreg(REG_CFG, 16'h00FE);
        repeat (3) @(posedge clk);
        #1 chk({9'h000, en, mir, rot, typ}, 16'h0000);
        rreg(REG_CFG, 16'h00FE);
        xfer(16'h1234, 16'h1234, 1'b1);
        wreg(REG_CFG, 16'h0011);
        xfer(16'hABCD, 16'hCDAB, 1'b0);
        wreg(REG_CFG, 16'h0001);
        xfer(16'hABCD, 16'hABCD, 1'b0);
        for (int t = 0; t < 8; t++)
        begin
            wreg(REG_CFG, {8'h00, t[2:0], 1'b0, t[0], t[1:0], 1'b1});
            repeat (3) @(posedge clk);
            #1 chk({10'h000, mir, rot, typ}, {10'h000, t[0], t[1:0], t[2:0]});
            chk({15'h0000, rsvd}, {15'h0000, t > 4});
        end
        // fill for 8 cycles with the sink stalled, by which time the fifo must refuse
        wreg(REG_CFG, 16'h0001);
        stall <= 1'b1;
        b = cnt;
        @(posedge clk);
        hv <= 1'b1;
        hd <= 16'hA000;
        n = 0;
        repeat (8)
        begin
            @(posedge clk);
            if (hrdy)
            begin
                n++;
                hd <= hd + 16'h0001;
            end
        end
        hv <= 1'b0;
        #1 chk({15'h0000, hrdy}, 16'h0000);
        chk({15'h0000, n >= FIFO_DEPTH && n <= FIFO_DEPTH + 2}, 16'h0001);
        stall <= 1'b0;
        wait_cnt(b + n[7:0]);
        chk(last, hd - 16'h0001);
        wreg(REG_CFG, 16'h800F);
        watch_srst(seen);
        chk({15'h0000, seen}, 16'h0001);
        rreg(REG_CFG, 16'h000E);
        chk({15'h0000, en}, 16'h0000);
        wreg(REG_CFG, 16'h0001);
        watch_srst(seen);
        chk({14'h0000, seen, en}, 16'h0001);
        wreg(REG_RSVD_A, 16'hFFFF);
        rreg(REG_CFG, 16'h0001);
        rreg(REG_STAT, 16'h0002);
        rreg(9'h1FE, 16'h0000);
        results();
    end
endmodule
`default_nettype wire
